/* sph_defs.svh */
// constants for the handshake serial port: offsets, fields, timings
// assumes a 200 MHz module clock and 32-bit word addressed registers
`ifndef SPH_DEFS_SVH
`define SPH_DEFS_SVH
// -----------------------------------------------------------------
// register word indexes (byte address is four times the index)
// -----------------------------------------------------------------
`define SPH_IDX_CTRL 3'h0
`define SPH_IDX_STAT 3'h1
`define SPH_IDX_TXD 3'h2
`define SPH_IDX_RXD 3'h3
`define SPH_IDX_TMO 3'h4
// -----------------------------------------------------------------
// control field positions
// -----------------------------------------------------------------
`define SPH_CF_RATE 2:0
`define SPH_CF_PAR 4:3
`define SPH_CF_DLY 6:5
`define SPH_CF_RTU 7
`define SPH_CF_ROLE 9:8
`define SPH_CF_SYNC 10
`define SPH_CF_HWCFG 11
`define SPH_CF_EXCH 12
`define SPH_CTRL_RST 13'h0004
// -----------------------------------------------------------------
// status bits; the low three are sticky, write one to clear
// -----------------------------------------------------------------
`define SPH_SB_TMO 0
`define SPH_SB_PERR 1
`define SPH_SB_OVR 2
`define SPH_SB_RXV 3
`define SPH_SB_HOLD 4
`define SPH_SB_RTS 5
`define SPH_SB_CTS 6
`define SPH_SB_KEY 7
`define SPH_SB_ROLE 9:8
`define SPH_SB_PAR 11:10
// -----------------------------------------------------------------
// characters and timing
// -----------------------------------------------------------------
`define SPH_EOT_CHAR 8'h04
`define SPH_CLK_HZ 200000000
`define SPH_DLY_SHORT_MS 10
`define SPH_DLY_LONG_MS 500
`define SPH_MS_CYC (`SPH_CLK_HZ / 1000)
`endif

/* sph_modem_model.sv */
// far side of the handshake serial port: a modem with rts/cts flow control
// assumes the port's line is idle high and one frame at a time each way
`timescale 1ns/1ps
module sph_modem_model #(
  parameter int BIT_CYC = 5208
) (
  // clock
  input wire logic clock,
  // line from the port
  input wire logic txd,
  input wire logic rts,
  // line toward the port
  output logic rxd,
  output logic cts,
  output logic modem_clk,
  // bench control
  input wire logic allow,
  input wire logic [1:0] par,
  input wire logic send,
  input wire logic [7:0] send_byte,
  // decoded characters
  output logic got,
  output logic [7:0] got_byte,
  output logic got_perr
);
  // -----------------------------------------------------------------
  // flow control and idle levels
  // -----------------------------------------------------------------
  // cts follows rts one clock later, so a dropped rts or allow drops cts on the next clock
  always @(posedge clock) begin
    cts <= allow & rts;
  end
  // -----------------------------------------------------------------
  // decode frames sent by the port, sampled mid bit
  // -----------------------------------------------------------------
  initial begin : decode
    logic [7:0] d;
    logic e;
    got = 1'b0;
    got_byte = 8'h00;
    got_perr = 1'b0;
    forever begin
      @(posedge clock);
      if (txd === 1'b0) begin
        repeat (BIT_CYC / 2) @(posedge clock);
        e = (txd !== 1'b0);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge clock);
          d[i] = txd;
        end
        if (par !== 2'h0) begin
          repeat (BIT_CYC) @(posedge clock);
          e = e | ((^{d, txd}) !== (par == 2'h1));
        end
        repeat (BIT_CYC) @(posedge clock);
        e = e | (txd !== 1'b1);
        got_byte <= d;
        got_perr <= e;
        got <= 1'b1;
        @(posedge clock);
        got <= 1'b0;
      end
    end
  end
  // -----------------------------------------------------------------
  // send one frame toward the port; modem clock runs only in frames
  // -----------------------------------------------------------------
  initial begin : drive
    logic [10:0] fr;
    int nb;
    rxd = 1'b1;
    modem_clk = 1'b0;
    forever begin
      @(posedge clock);
      if (send === 1'b1) begin
        fr = {1'b1, ~^send_byte ^ (par == 2'h2), send_byte, 1'b0};
        if (par == 2'h0) begin
          fr = {2'b11, send_byte, 1'b0};
        end
        nb = (par == 2'h0) ? 10 : 11;
        for (int i = 0; i < nb; i++) begin
          rxd <= fr[i];
          modem_clk <= 1'b0;
          repeat (BIT_CYC / 2) @(posedge clock);
          modem_clk <= 1'b1;
          repeat (BIT_CYC - BIT_CYC / 2) @(posedge clock);
        end
        rxd <= 1'b1;
        modem_clk <= 1'b0;
      end
    end
  end
endmodule // sph_modem_model

/* sph_pkg.sv */
// types shared by the handshake serial port
// assumes nothing beyond a SystemVerilog compiler
package sph_pkg;
  typedef enum logic [1:0] {
    SPH_TX_IDLE = 2'b00,
    SPH_TX_TURN = 2'b01,
    SPH_TX_SEND = 2'b10,
    SPH_TX_WAIT = 2'b11
  } sph_tx_state_t;
  typedef enum logic [1:0] {
    SPH_PAR_NONE = 2'b00,
    SPH_PAR_ODD = 2'b01,
    SPH_PAR_EVEN = 2'b10
  } sph_par_t;
endpackage

/* sph_uart.sv */
// serial port with rts/cts flow control, turn-around delay, radio key,
// link time-out with eot abort, parity framing and a clocked variant.
// assumes an avalon-mm master on the module clock; pins are asynchronous.
// Function
// - rts stays false while nothing waits to be sent
// - a queued character raises rts before anything is sent
// - after the turn-around delay, sending starts only with cts true
// - rts drops once the last character has fully shifted out
// - cts false pauses at the next character boundary until true
// - the receiver takes characters regardless of rts and cts
// - turn-around delay selectable: zero, ten or five hundred ms
// - radio key asserted for the whole turn-around delay
// - every link time-out is lengthened by the turn-around delay
// - an expired time-out abandons the exchange and sends eot
// - long delay with time-outs disabled ignores all time-outs
// - native mode odd or none; remote-terminal mode odd, even, none
// - frame: start, eight data lsb first, optional parity, stop
// - with parity off the stop bit follows the eighth data bit
// - clocked option drives a bit-rate clock, samples on modem clock
// - the same flow control holds on the differential interface
// - master, slave or peer natively; slave only for remote-terminal
// - bit rates 300 to 38400 selected by configuration
// - switch configuration forces odd parity
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`include "sph_defs.svh"
module sph_uart #(
  parameter int unsigned DLY_SHORT_CYC = `SPH_DLY_SHORT_MS * `SPH_MS_CYC,
  parameter int unsigned DLY_LONG_CYC = `SPH_DLY_LONG_MS * `SPH_MS_CYC,
  parameter int unsigned MS_CYC = `SPH_MS_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // serial line
  output logic txd,
  input wire logic rxd,
  output logic rts,
  input wire logic cts,
  output logic radio_key,
  // clocked differential option
  output logic tx_clk_out,
  input wire logic modem_clk
);
  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  logic [1:0] rxd_s, cts_s, mclk_s;
  logic mclk_prev_q;
  // first stage read only by the second stage
  always_ff @(posedge clock) begin
    if (rst) begin
      rxd_s <= 2'h3;
      cts_s <= 2'h0;
      mclk_s <= 2'h0;
      mclk_prev_q <= 1'b0;
    end else begin
      rxd_s <= {rxd_s[0], rxd};
      cts_s <= {cts_s[0], cts};
      mclk_s <= {mclk_s[0], modem_clk};
      mclk_prev_q <= mclk_s[1];
    end
  end
  wire rx_in = rxd_s[1];
  wire cts_in = cts_s[1];
  wire mclk_rise = mclk_s[1] & ~mclk_prev_q;
  // -----------------------------------------------------------------
  // configuration and derived settings
  // -----------------------------------------------------------------
  logic [12:0] ctrl_q;
  logic [15:0] tmo_ms_q;
  logic [2:0] stat_q;
  sph_pkg::sph_par_t par_eff;
  logic [1:0] role_eff;
  logic [31:0] bit_cyc, dly_cyc, tmo_lim;
  // parity coercion per mode and configuration source
  always_comb begin
    if (ctrl_q[`SPH_CF_HWCFG])
      par_eff = sph_pkg::SPH_PAR_ODD;
    else if (ctrl_q[`SPH_CF_PAR] == 2'h0)
      par_eff = sph_pkg::SPH_PAR_NONE;
    else if (ctrl_q[`SPH_CF_RTU] && ctrl_q[`SPH_CF_PAR] == 2'h2)
      par_eff = sph_pkg::SPH_PAR_EVEN;
    else
      par_eff = sph_pkg::SPH_PAR_ODD;
    // remote-terminal mode only serves as slave
    role_eff = ctrl_q[`SPH_CF_RTU] ? 2'h1 : ctrl_q[`SPH_CF_ROLE];
  end
  // divider per rate code: 300 doubling up to 38400
  always_comb begin
    bit_cyc = 32'(`SPH_CLK_HZ / (300 << ctrl_q[`SPH_CF_RATE]));
    case (ctrl_q[`SPH_CF_DLY])
      2'h0: dly_cyc = 32'h0;
      2'h1: dly_cyc = DLY_SHORT_CYC;
      default: dly_cyc = DLY_LONG_CYC;
    endcase
    // time-out stretched by the turn-around delay
    tmo_lim = 32'(tmo_ms_q * MS_CYC) + dly_cyc;
  end
  wire tmo_off = (ctrl_q[`SPH_CF_DLY] == 2'h3) ||
                 (tmo_ms_q == 16'h0);
  wire has_par = (par_eff != sph_pkg::SPH_PAR_NONE);
  // -----------------------------------------------------------------
  // bus slave: one wait state, registered read data
  // -----------------------------------------------------------------
  logic ack_q;
  logic [7:0] hold_q, rxbuf_q;
  logic hold_v_q, rx_v_q;
  wire tx_stall = write && address == `SPH_IDX_TXD && hold_v_q;
  wire wr = ack_q & write;
  wire rd = ack_q & read;
  assign waitrequest = ~ack_q;
  // tx writes stall while the holding register is full
  always_ff @(posedge clock) begin
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= (read | write) & ~ack_q & ~tx_stall;
  end
  // read mux; unmapped words read zero
  always_ff @(posedge clock) begin
    if (rst) begin
      readdata <= 32'h0;
    end else if ((read | write) & ~ack_q) begin
      case (address)
        `SPH_IDX_CTRL: readdata <= {19'h0, ctrl_q};
        `SPH_IDX_STAT: readdata <= {20'h0, par_eff, role_eff, radio_key,
                                    cts_in, rts, hold_v_q, rx_v_q, stat_q};
        `SPH_IDX_RXD: readdata <= {24'h0, rxbuf_q};
        `SPH_IDX_TMO: readdata <= {16'h0, tmo_ms_q};
        default: readdata <= 32'h0;
      endcase
    end
  end
  // -----------------------------------------------------------------
  // time-out timer
  // -----------------------------------------------------------------
  logic [31:0] tmo_cnt_q;
  logic tx_done, rx_done, rx_perr;
  wire tmo_fire = ctrl_q[`SPH_CF_EXCH] && !tmo_off && tmo_cnt_q >= tmo_lim;
  // restarts when any character completes, so a character still in progress does not hold it off
  always_ff @(posedge clock) begin
    if (rst || !ctrl_q[`SPH_CF_EXCH] || tx_done || rx_done || tmo_fire)
      tmo_cnt_q <= 32'h0;
    else
      tmo_cnt_q <= tmo_cnt_q + 32'h1;
  end
  // control registers; hardware ends the exchange on time-out
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= `SPH_CTRL_RST;
      tmo_ms_q <= 16'h0;
    end else begin
      if (wr && address == `SPH_IDX_CTRL)
        ctrl_q <= writedata[12:0];
      if (wr && address == `SPH_IDX_TMO)
        tmo_ms_q <= writedata[15:0];
      if (tmo_fire)
        ctrl_q[`SPH_CF_EXCH] <= 1'b0;
    end
  end
  // -----------------------------------------------------------------
  // transmit holding register
  // -----------------------------------------------------------------
  sph_pkg::sph_tx_state_t tx_st_q;
  logic tx_load;
  // abort overrides any queued data with an end-of-transmission
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_q <= 8'h0;
      hold_v_q <= 1'b0;
    end else if (tmo_fire) begin
      hold_q <= `SPH_EOT_CHAR;
      hold_v_q <= 1'b1;
    end else if (wr && address == `SPH_IDX_TXD) begin
      hold_q <= writedata[7:0];
      hold_v_q <= 1'b1;
    end else if (tx_load) begin
      hold_v_q <= 1'b0;
    end
  end
  // -----------------------------------------------------------------
  // transmit engine
  // -----------------------------------------------------------------
  logic [10:0] tx_sh_q;
  logic [3:0] tx_bits_q;
  logic [31:0] tx_tmr_q;
  logic [31:0] turn_q;
  wire tx_tick = (tx_tmr_q == 32'h0);
  assign tx_load = hold_v_q && cts_in && !tmo_fire &&
                   ((tx_st_q == sph_pkg::SPH_TX_TURN && turn_q == 32'h0) ||
                    (tx_st_q == sph_pkg::SPH_TX_WAIT));
  assign tx_done = (tx_st_q == sph_pkg::SPH_TX_SEND) && tx_tick &&
                   tx_bits_q == 4'h1;
  // handshake state: cts checked only between characters
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_st_q <= sph_pkg::SPH_TX_IDLE;
      turn_q <= 32'h0;
    end else begin
      case (tx_st_q)
        sph_pkg::SPH_TX_IDLE: begin
          if (hold_v_q) begin
            tx_st_q <= sph_pkg::SPH_TX_TURN;
            turn_q <= dly_cyc;
          end
        end
        sph_pkg::SPH_TX_TURN: begin
          if (turn_q != 32'h0)
            turn_q <= turn_q - 32'h1;
          else if (tx_load)
            tx_st_q <= sph_pkg::SPH_TX_SEND;
        end
        sph_pkg::SPH_TX_SEND: begin
          if (tx_done)
            tx_st_q <= sph_pkg::SPH_TX_WAIT;
        end
        sph_pkg::SPH_TX_WAIT: begin
          if (!hold_v_q)
            tx_st_q <= sph_pkg::SPH_TX_IDLE;
          else if (tx_load)
            tx_st_q <= sph_pkg::SPH_TX_SEND;
        end
        default: tx_st_q <= sph_pkg::SPH_TX_IDLE;
      endcase
    end
  end
  // shifter: frame built lsb first, parity slot dropped when off
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_sh_q <= 11'h7FF;
      tx_bits_q <= 4'h0;
      tx_tmr_q <= 32'h0;
    end else if (tx_load) begin
      if (has_par)
        tx_sh_q <= {1'b1, (^hold_q) ^ (par_eff == sph_pkg::SPH_PAR_ODD),
                    hold_q, 1'b0};
      else
        tx_sh_q <= {2'b11, hold_q, 1'b0};
      tx_bits_q <= has_par ? 4'hB : 4'hA;
      tx_tmr_q <= bit_cyc - 32'h1;
    end else if (tx_st_q == sph_pkg::SPH_TX_SEND) begin
      if (tx_tick) begin
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        tx_bits_q <= tx_bits_q - 4'h1;
        tx_tmr_q <= bit_cyc - 32'h1;
      end else begin
        tx_tmr_q <= tx_tmr_q - 32'h1;
      end
    end
  end
  // line outputs from flops
  always_ff @(posedge clock) begin
    if (rst) begin
      txd <= 1'b1;
      rts <= 1'b0;
      radio_key <= 1'b0;
    end else begin
      txd <= (tx_st_q == sph_pkg::SPH_TX_SEND) ? tx_sh_q[0] : 1'b1;
      rts <= (tx_st_q != sph_pkg::SPH_TX_IDLE);
      radio_key <= (tx_st_q == sph_pkg::SPH_TX_TURN) && (turn_q != 32'h0);
    end
  end
  // -----------------------------------------------------------------
  // transmit clock for the clocked option
  // -----------------------------------------------------------------
  logic [31:0] tclk_cnt_q;
  // square wave at the bit rate, idle low when the option is off
  always_ff @(posedge clock) begin
    if (rst || !ctrl_q[`SPH_CF_SYNC]) begin
      tclk_cnt_q <= 32'h0;
      tx_clk_out <= 1'b0;
    end else if (tclk_cnt_q >= (bit_cyc >> 1) - 32'h1) begin
      tclk_cnt_q <= 32'h0;
      tx_clk_out <= ~tx_clk_out;
    end else begin
      tclk_cnt_q <= tclk_cnt_q + 32'h1;
    end
  end
  // -----------------------------------------------------------------
  // receiver, never gated by the handshake lines
  // -----------------------------------------------------------------
  logic rx_busy_q;
  logic [3:0] rx_bits_q;
  logic [9:0] rx_sh_q;
  logic [31:0] rx_tmr_q;
  logic rx_in_prev_q;
  wire sync = ctrl_q[`SPH_CF_SYNC];
  wire rx_start = !rx_busy_q &&
                  (sync ? (mclk_rise && !rx_in) : (rx_in_prev_q && !rx_in));
  wire rx_samp = rx_busy_q && (sync ? mclk_rise : rx_tmr_q == 32'h0);
  assign rx_done = rx_samp && rx_bits_q == 4'h1;
  // at the stop-bit sample the earlier bits still sit at the top, the stop bit not yet shifted in
  wire [7:0] rx_byte = has_par ? rx_sh_q[8:1] : rx_sh_q[9:2];
  wire rx_pbit = rx_sh_q[9];
  assign rx_perr = has_par && (((^rx_byte) ^ rx_pbit) !=
                               (par_eff == sph_pkg::SPH_PAR_ODD));
  // async sampling mid-bit from a bit-and-a-half start offset
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_busy_q <= 1'b0;
      rx_bits_q <= 4'h0;
      rx_sh_q <= 10'h0;
      rx_tmr_q <= 32'h0;
      rx_in_prev_q <= 1'b1;
    end else begin
      rx_in_prev_q <= rx_in;
      if (rx_start) begin
        rx_busy_q <= 1'b1;
        rx_bits_q <= has_par ? 4'hA : 4'h9;
        rx_tmr_q <= (bit_cyc >> 1) + bit_cyc - 32'h1;
      end else if (rx_samp) begin
        rx_sh_q <= {rx_in, rx_sh_q[9:1]};
        rx_bits_q <= rx_bits_q - 4'h1;
        rx_tmr_q <= bit_cyc - 32'h1;
        if (rx_bits_q == 4'h1)
          rx_busy_q <= 1'b0;
      end else if (rx_busy_q && rx_tmr_q != 32'h0) begin
        rx_tmr_q <= rx_tmr_q - 32'h1;
      end
    end
  end
  // completed byte capture; stop bit is the newest sample
  always_ff @(posedge clock) begin
    if (rst) begin
      rxbuf_q <= 8'h0;
      rx_v_q <= 1'b0;
    end else if (rx_done) begin
      rxbuf_q <= rx_byte;
      rx_v_q <= 1'b1;
    end else if (rd && address == `SPH_IDX_RXD) begin
      rx_v_q <= 1'b0;
    end
  end
  // sticky status: a new event wins over a write-one clear
  always_ff @(posedge clock) begin
    if (rst) begin
      stat_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr && address == `SPH_IDX_STAT && writedata[i])
          stat_q[i] <= 1'b0;
      end
      if (tmo_fire)
        stat_q[`SPH_SB_TMO] <= 1'b1;
      if (rx_done && rx_perr)
        stat_q[`SPH_SB_PERR] <= 1'b1;
      if (rx_done && rx_v_q && !(rd && address == `SPH_IDX_RXD))
        stat_q[`SPH_SB_OVR] <= 1'b1;
    end
  end
  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  sequence s_turn_start;
    tx_st_q == sph_pkg::SPH_TX_IDLE && hold_v_q;
  endsequence
  chk_rts_idle_low: assert property (@(posedge clock) disable iff (rst)
    $past(tx_st_q) == sph_pkg::SPH_TX_IDLE && !$past(rst) |-> !rts)
    else $error("rts high with nothing to send");
  chk_rts_before_tx: assert property (@(posedge clock) disable iff (rst)
    s_turn_start ##1 1'b1 |=> rts)
    else $error("rts not raised after data queued");
  chk_cts_gate: assert property (@(posedge clock) disable iff (rst)
    $rose(tx_st_q == sph_pkg::SPH_TX_SEND) |-> $past(cts_in) &&
    $past(turn_q) == 32'h0)
    else $error("character started without cts or before delay");
  chk_rts_drop: assert property (@(posedge clock) disable iff (rst)
    tx_st_q == sph_pkg::SPH_TX_WAIT && !hold_v_q |=> ##1 !rts)
    else $error("rts kept after last character");
  chk_pause_cts: assert property (@(posedge clock) disable iff (rst)
    tx_st_q == sph_pkg::SPH_TX_WAIT && hold_v_q && !cts_in
    |=> tx_st_q == sph_pkg::SPH_TX_WAIT)
    else $error("sent while cts false");
  chk_key_turn: assert property (@(posedge clock) disable iff (rst)
    tx_st_q == sph_pkg::SPH_TX_TURN && turn_q > 32'h1 |=> ##1 radio_key)
    else $error("radio key missing during delay");
  chk_tmo_eot: assert property (@(posedge clock) disable iff (rst)
    tmo_fire |=> hold_v_q && hold_q == `SPH_EOT_CHAR &&
    !ctrl_q[`SPH_CF_EXCH])
    else $error("time-out did not queue eot");
  chk_tmo_ignored: assert property (@(posedge clock) disable iff (rst)
    ctrl_q[`SPH_CF_DLY] == 2'h3 |-> !tmo_fire)
    else $error("time-out acted while disabled");
  chk_par_mode: assert property (@(posedge clock) disable iff (rst)
    !ctrl_q[`SPH_CF_RTU] |-> par_eff != sph_pkg::SPH_PAR_EVEN)
    else $error("even parity in native mode");
  chk_frame_len: assert property (@(posedge clock) disable iff (rst)
    tx_load |=> tx_bits_q == (has_par ? 4'hB : 4'hA))
    else $error("frame length wrong for parity setting");
endmodule // sph_uart

/* tb_serial_port_handshake_uart.sv */
// self-checking bench for the handshake serial port
// assumes short delay parameters and the fastest bit rate to keep runs short
`timescale 1ns/1ps
`include "sph_defs.svh"
module tb_serial_port_handshake_uart;
  localparam int SHORT = 50;
  localparam int MSC = 20;
  localparam int BITC = 200000000 / (300 << 7);
  localparam logic [31:0] CFG [5] = '{32'h10, 32'h90, 32'h280, 32'h200,
    32'h800};
  localparam logic [1:0] EPAR [5] = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h1};
  localparam logic [1:0] EROLE [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [2:0] address = 3'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, txd, rxd, rts, cts, radio_key, tx_clk_out, modem_clk;
  logic allow = 1'b0;
  logic [1:0] mpar = 2'h1;
  logic send = 1'b0;
  logic [7:0] send_byte = 8'h00;
  logic got, got_perr;
  logic [7:0] got_byte;
  int fails = 0;
  int check_count = 0;
  int unsigned seed = 5;
  logic [7:0] exp_q [$];
  // -----------------------------------------------------------------
  // clock, design and far side
  // -----------------------------------------------------------------
  initial begin
    forever #2.5 clock = ~clock;
  end
  sph_uart #(.DLY_SHORT_CYC(SHORT), .DLY_LONG_CYC(200), .MS_CYC(MSC)) uut (
    .clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .txd(txd), .rxd(rxd), .rts(rts),
    .cts(cts), .radio_key(radio_key), .tx_clk_out(tx_clk_out),
    .modem_clk(modem_clk));
  sph_modem_model #(.BIT_CYC(BITC)) modem (
    .clock(clock), .txd(txd), .rts(rts), .rxd(rxd), .cts(cts),
    .modem_clk(modem_clk), .allow(allow), .par(mpar), .send(send),
    .send_byte(send_byte), .got(got), .got_byte(got_byte),
    .got_perr(got_perr));
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task check_word(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task check_bit(input string nm, input logic e, input logic g);
    check_word(nm, {31'h0, e}, {31'h0, g});
  endtask
  // one avalon access, held until waitrequest is sampled low
  task bus(input logic we, input logic [2:0] a, input logic [31:0] wd,
    output logic [31:0] d);
    int k;
    k = 0;
    address <= a;
    writedata <= wd;
    write <= we;
    read <= ~we;
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      k++;
      if (k > 1000) begin
        check_word("bus_wait", 32'h1, 32'h0);
        summarize();
      end
      @(posedge clock);
    end
    d = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clock);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return rts;
      1: return got;
      default: return tx_clk_out;
    endcase
  endfunction
  // bounded wait for a pin level; gives back the cycles it took
  task wait_pin(input int s, input logic lvl, input int lim, output int k);
    k = 0;
    while (pick(s) !== lvl) begin
      @(posedge clock);
      k++;
      if (k > lim) begin
        check_word("wait_pin", {31'h0, lvl}, {31'h0, ~lvl});
        summarize();
      end
    end
  endtask
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin : main
    logic [31:0] rd;
    logic [7:0] b1;
    int n, bad, keyoff;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check_bit("txd", 1'b1, txd);
    check_bit("rts", 1'b0, rts);
    check_bit("radio_key", 1'b0, radio_key);
    bus(1'b0, `SPH_IDX_CTRL, 32'h0, rd);
    check_word("ctrl", 32'h4, rd);
    bus(1'b0, 3'h5, 32'h0, rd);
    check_word("unmapped", 32'h0, rd);
    // mode coercions seen through the effective fields
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, `SPH_IDX_CTRL, 32'h7 | CFG[i], rd);
      bus(1'b0, `SPH_IDX_STAT, 32'h0, rd);
      check_word("eff_par", {30'h0, EPAR[i]}, {30'h0, rd[11:10]});
      check_word("eff_role", {30'h0, EROLE[i]}, {30'h0, rd[9:8]});
    end
    // long delay with time-outs off never aborts
    bus(1'b1, `SPH_IDX_STAT, 32'h7, rd);
    bus(1'b1, `SPH_IDX_TMO, 32'h1, rd);
    bus(1'b1, `SPH_IDX_CTRL, 32'h1067, rd);
    repeat (400) @(posedge clock);
    bus(1'b0, `SPH_IDX_STAT, 32'h0, rd);
    check_bit("tmo_flag", 1'b0, rd[0]);
    check_bit("rts", 1'b0, rts);
    // transmit held off by cts while a character arrives on modem clocks
    bus(1'b1, `SPH_IDX_TMO, 32'h0, rd);
    bus(1'b1, `SPH_IDX_CTRL, 32'h42F, rd);
    b1 = xs();
    send_byte <= xs();
    send <= 1'b1;
    @(posedge clock);
    send <= 1'b0;
    check_bit("rts", 1'b0, rts);
    exp_q.push_back(b1);
    bus(1'b1, `SPH_IDX_TXD, {24'h0, b1}, rd);
    wait_pin(0, 1'b1, 10, n);
    bad = 0;
    keyoff = 0;
    for (int k = 0; k < SHORT + 100; k++) begin
      @(posedge clock);
      bad += (txd !== 1'b1);
      keyoff += (k < SHORT - 5 && radio_key !== 1'b1);
    end
    check_word("txd_low", 32'h0, bad);
    check_word("key_off", 32'h0, keyoff);
    allow <= 1'b1;
    // transmit clock half period, measured while the frame goes out
    wait_pin(2, 1'b1, BITC + 10, n);
    wait_pin(2, 1'b0, BITC + 10, n);
    check_bit("clk_half", 1'b1, n >= BITC/2-3 && n <= BITC/2+3);
    wait_pin(1, 1'b1, BITC * 12, n);
    check_word("tx_byte", {24'h0, exp_q.pop_front()}, 32'(got_byte));
    check_bit("tx_frame_err", 1'b0, got_perr);
    wait_pin(0, 1'b0, BITC, n);
    bus(1'b0, `SPH_IDX_STAT, 32'h0, rd);
    check_bit("rx_valid", 1'b1, rd[`SPH_SB_RXV]);
    check_bit("rx_perr", 1'b0, rd[`SPH_SB_PERR]);
    bus(1'b0, `SPH_IDX_RXD, 32'h0, rd);
    check_word("rx_byte", {24'h0, send_byte}, {24'h0, rd[7:0]});
    // link time-out, lengthened by the delay, ends in eot
    mpar <= 2'h0;
    exp_q.push_back(`SPH_EOT_CHAR);
    bus(1'b1, `SPH_IDX_TMO, 32'h1, rd);
    bus(1'b1, `SPH_IDX_CTRL, 32'h1027, rd);
    // an unclocked character arrives while the exchange times out
    send_byte <= xs();
    send <= 1'b1;
    @(posedge clock);
    send <= 1'b0;
    bad = 0;
    for (int k = 0; k < MSC + SHORT - 10; k++) begin
      @(posedge clock);
      bad += (rts !== 1'b0);
    end
    check_word("early_rts", 32'h0, bad);
    wait_pin(0, 1'b1, 40, n);
    wait_pin(1, 1'b1, BITC * 12, n);
    check_word("eot", {24'h0, exp_q.pop_front()}, {24'h0, got_byte});
    check_bit("frame_err", 1'b0, got_perr);
    bus(1'b0, `SPH_IDX_STAT, 32'h0, rd);
    check_bit("tmo_flag", 1'b1, rd[`SPH_SB_TMO]);
    check_bit("rx_valid", 1'b1, rd[`SPH_SB_RXV]);
    bus(1'b0, `SPH_IDX_RXD, 32'h0, rd);
    check_word("rx_byte", {24'h0, send_byte}, {24'h0, rd[7:0]});
    summarize();
  end
endmodule // tb_serial_port_handshake_uart
